// [status_reporting_summary.sv]
// status reporting: condition, event, enable registers and service request
`timescale 1ns/1ns
`default_nettype none
`include "status_defines.svh"

module status_reporting_summary #(
  parameter int WIDE_W = `WIDE_W,
  parameter int NARROW_W = `NARROW_W
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // device conditions
  input wire status_pkg::op_in_t op_in_i,
  input wire status_pkg::q_in_t q_in_i,
  input wire logic [NARROW_W-1:0] std_cond_i,
  input wire logic trig_pin_i,
  input wire logic queue_not_empty_i,
  input wire logic out_data_avail_i,
  // register access from the command parser
  input wire status_pkg::reg_sel_t reg_sel_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [WIDE_W-1:0] wdata_i,
  output logic [WIDE_W-1:0] rdata_o,
  output logic rd_valid_o,
  // host side
  output logic [NARROW_W-1:0] serial_poll_o,
  output logic srq_o
);

  // ****************************************
  // event update
  // ****************************************
  function automatic logic [WIDE_W-1:0] evt_next(
    input logic [WIDE_W-1:0] evt,
    input logic [WIDE_W-1:0] cond,
    input logic [WIDE_W-1:0] prev,
    input logic [WIDE_W-1:0] pulse,
    input logic clr
  );
    logic [WIDE_W-1:0] held;
    held = clr ? '0 : evt;
    evt_next = held | (cond & ~prev) | pulse;
  endfunction

  function automatic logic hit(
    input status_pkg::reg_sel_t sel,
    input status_pkg::reg_sel_t want,
    input logic strobe
  );
    hit = strobe && (sel == want);
  endfunction

  function automatic logic [WIDE_W-1:0] widen(
    input logic [NARROW_W-1:0] v
  );
    widen = {{(WIDE_W-NARROW_W){1'b0}}, v};
  endfunction

  // ****************************************
  // trigger pin synchroniser
  // ****************************************
  logic trig_meta_r;
  logic trig_sync_r;
  logic trig_prev_r;
  logic trig_hold_r;
  logic trig_hold_nxt;
  wire trig_fall = trig_prev_r & ~trig_sync_r;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trig_meta_r <= 1'b1;
      trig_sync_r <= 1'b1;
      trig_prev_r <= 1'b1;
      trig_hold_r <= 1'b0;
    end else begin
      trig_meta_r <= trig_pin_i;
      trig_sync_r <= trig_meta_r;
      trig_prev_r <= trig_sync_r;
      trig_hold_r <= trig_hold_nxt;
    end
  end

  // wait flag rises on a falling pin edge and stays up until the pin returns high
  assign trig_hold_nxt = op_in_i.trig_ext_src &&
    (trig_fall || (trig_hold_r && !trig_sync_r));

  // ****************************************
  // operation condition
  // ****************************************
  logic [WIDE_W-1:0] op_cond;
  logic [WIDE_W-1:0] op_pulse;

  always_comb begin
    op_cond = '0;
    op_cond[`OP_TRIG_WAIT] = op_in_i.trig_enabled | trig_hold_r;
    op_cond[`OP_TRAN_ARMED] = op_in_i.transient_armed;
    op_cond[`OP_CONST_VOLT] = op_in_i.const_volt;
    op_cond[`OP_CONST_CURR] = op_in_i.const_curr;
    op_cond[`OP_SAMPLE_DONE] = op_in_i.sample_done;
    op_cond[`OP_LIST_RUN] = op_in_i.list_running;
  end

  // transient and list completion bits reach the event register only
  always_comb begin
    op_pulse = '0;
    op_pulse[`OP_TRAN_DONE] = op_in_i.transient_done;
    op_pulse[`OP_LIST_DONE] = op_in_i.list_done;
  end

  // ****************************************
  // quality condition
  // ****************************************
  logic [WIDE_W-1:0] q_cond;
  wire any_prot = q_in_i.volt_prot | q_in_i.curr_prot;

  always_comb begin
    q_cond = '0;
    q_cond[`Q_VOLT_ERR] = q_in_i.current_mode;
    q_cond[`Q_CURR_ERR] = q_in_i.voltage_mode;
    q_cond[`Q_THERMAL] = q_in_i.thermal_fault;
    q_cond[`Q_SLAVE] = q_in_i.slave_fault;
    q_cond[`Q_VOLT_PROT] = q_in_i.ext_ref ? any_prot
      : q_in_i.volt_prot;
    q_cond[`Q_CURR_PROT] = q_in_i.ext_ref ? any_prot
      : q_in_i.curr_prot;
    q_cond[`Q_SINKING] = q_in_i.sinking;
  end

  // ****************************************
  // register file
  // ****************************************
  logic [WIDE_W-1:0] op_prev_r;
  logic [WIDE_W-1:0] op_evt_r;
  logic [WIDE_W-1:0] op_evt_nxt;
  logic [WIDE_W-1:0] op_ena_r;
  logic [WIDE_W-1:0] q_prev_r;
  logic [WIDE_W-1:0] q_evt_r;
  logic [WIDE_W-1:0] q_evt_nxt;
  logic [WIDE_W-1:0] q_ena_r;
  logic [NARROW_W-1:0] std_prev_r;
  logic [NARROW_W-1:0] std_evt_r;
  logic [NARROW_W-1:0] std_evt_nxt;
  logic [NARROW_W-1:0] std_ena_r;
  logic [NARROW_W-1:0] srv_ena_r;

  wire rd_op_evt = hit(reg_sel_i, status_pkg::SEL_OP_EVT, rd_i);
  wire rd_q_evt = hit(reg_sel_i, status_pkg::SEL_Q_EVT, rd_i);
  wire rd_std_evt = hit(reg_sel_i, status_pkg::SEL_STD_EVT, rd_i);
  wire wr_op_ena = hit(reg_sel_i, status_pkg::SEL_OP_ENA, wr_i);
  wire wr_q_ena = hit(reg_sel_i, status_pkg::SEL_Q_ENA, wr_i);
  wire wr_std_ena = hit(reg_sel_i, status_pkg::SEL_STD_ENA, wr_i);
  wire wr_srv_ena = hit(reg_sel_i, status_pkg::SEL_SRV_ENA, wr_i);

  logic [WIDE_W-1:0] std_cond_w;
  logic [WIDE_W-1:0] std_prev_w;
  logic [WIDE_W-1:0] std_evt_w;
  logic [WIDE_W-1:0] std_calc;

  assign std_cond_w = widen(std_cond_i);
  assign std_prev_w = widen(std_prev_r);
  assign std_evt_w = widen(std_evt_r);

  // a new edge in the read cycle survives the clear
  assign op_evt_nxt = evt_next(op_evt_r, op_cond, op_prev_r,
    op_pulse, rd_op_evt);
  assign q_evt_nxt = evt_next(q_evt_r, q_cond, q_prev_r,
    '0, rd_q_evt);
  assign std_calc = evt_next(std_evt_w, std_cond_w, std_prev_w,
    '0, rd_std_evt);
  assign std_evt_nxt = std_calc[NARROW_W-1:0];

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_prev_r <= `WIDE_ZERO;
    end else begin
      op_prev_r <= op_cond;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_prev_r <= `WIDE_ZERO;
    end else begin
      q_prev_r <= q_cond;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      std_prev_r <= `NARROW_ZERO;
    end else begin
      std_prev_r <= std_cond_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_evt_r <= `WIDE_ZERO;
    end else begin
      op_evt_r <= op_evt_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_evt_r <= `WIDE_ZERO;
    end else begin
      q_evt_r <= q_evt_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      std_evt_r <= `NARROW_ZERO;
    end else begin
      std_evt_r <= std_evt_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_ena_r <= `WIDE_ZERO;
    end else if (wr_op_ena) begin
      op_ena_r <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_ena_r <= `WIDE_ZERO;
    end else if (wr_q_ena) begin
      q_ena_r <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      std_ena_r <= `NARROW_ZERO;
    end else if (wr_std_ena) begin
      std_ena_r <= wdata_i[NARROW_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      srv_ena_r <= `NARROW_ZERO;
    end else if (wr_srv_ena) begin
      srv_ena_r <= wdata_i[NARROW_W-1:0];
    end
  end

  // ****************************************
  // summaries and service request
  // ****************************************
  wire op_sum = |(op_evt_r & op_ena_r);
  wire q_sum = |(q_evt_r & q_ena_r);
  wire std_sum = |(std_evt_r & std_ena_r);
  logic [NARROW_W-1:0] srv_base;
  logic [NARROW_W-1:0] srv_mask;
  logic [NARROW_W-1:0] srv_byte;
  wire srv_req;

  // error bit stays zero while queue empty and no quality event
  always_comb begin
    srv_base = '0;
    srv_base[`SRV_QUALITY] = q_sum | queue_not_empty_i;
    srv_base[`SRV_DATA_AVAIL] = out_data_avail_i;
    srv_base[`SRV_STD_SUM] = std_sum;
    srv_base[`SRV_OP_SUM] = op_sum;
  end

  always_comb begin
    srv_mask = srv_ena_r;
    srv_mask[`SRV_REQUEST] = 1'b0;
  end

  assign srv_req = |(srv_base & srv_mask);

  always_comb begin
    srv_byte = srv_base;
    srv_byte[`SRV_REQUEST] = srv_req;
  end

  assign serial_poll_o = srv_byte;
  assign srq_o = srv_req;

  // ****************************************
  // read data
  // ****************************************
  logic [WIDE_W-1:0] rd_mux;
  logic [WIDE_W-1:0] rdata_r;
  logic rd_valid_r;

  always_comb begin
    unique case (reg_sel_i)
      status_pkg::SEL_OP_COND: rd_mux = op_cond;
      status_pkg::SEL_OP_EVT: rd_mux = op_evt_r;
      status_pkg::SEL_OP_ENA: rd_mux = op_ena_r;
      status_pkg::SEL_Q_COND: rd_mux = q_cond;
      status_pkg::SEL_Q_EVT: rd_mux = q_evt_r;
      status_pkg::SEL_Q_ENA: rd_mux = q_ena_r;
      status_pkg::SEL_STD_COND: rd_mux = std_cond_w;
      status_pkg::SEL_STD_EVT: rd_mux = std_evt_w;
      status_pkg::SEL_STD_ENA: rd_mux = widen(std_ena_r);
      status_pkg::SEL_SRV_BYTE: rd_mux = widen(srv_byte);
      status_pkg::SEL_SRV_ENA: rd_mux = widen(srv_ena_r);
      default: rd_mux = `WIDE_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= `WIDE_ZERO;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_i;
      if (rd_i) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign rdata_o = rdata_r;
  assign rd_valid_o = rd_valid_r;

endmodule

`default_nettype wire

// [status_defines.svh]
// status reporting constants: widths, bit positions, register selects
`ifndef STATUS_DEFINES_SVH
`define STATUS_DEFINES_SVH

// ****************************************
// register widths
// ****************************************
`define WIDE_W 16
`define NARROW_W 8
`define SEL_W 4

// ****************************************
// register select codes
// ****************************************
`define SEL_OP_COND 4'h0
`define SEL_OP_EVT 4'h1
`define SEL_OP_ENA 4'h2
`define SEL_Q_COND 4'h3
`define SEL_Q_EVT 4'h4
`define SEL_Q_ENA 4'h5
`define SEL_STD_COND 4'h6
`define SEL_STD_EVT 4'h7
`define SEL_STD_ENA 4'h8
`define SEL_SRV_BYTE 4'h9
`define SEL_SRV_ENA 4'ha

// ****************************************
// operation bit positions
// ****************************************
`define OP_TRIG_WAIT 5
`define OP_TRAN_ARMED 6
`define OP_CONST_VOLT 8
`define OP_TRAN_DONE 9
`define OP_CONST_CURR 10
`define OP_SAMPLE_DONE 11
`define OP_LIST_DONE 12
`define OP_LIST_RUN 14

// ****************************************
// quality bit positions
// ****************************************
`define Q_VOLT_ERR 0
`define Q_CURR_ERR 1
`define Q_THERMAL 3
`define Q_SLAVE 6
`define Q_VOLT_PROT 12
`define Q_CURR_PROT 13
`define Q_SINKING 14

// ****************************************
// service request bit positions
// ****************************************
`define SRV_QUEUE 3
`define SRV_QUALITY 3
`define SRV_DATA_AVAIL 4
`define SRV_STD_SUM 5
`define SRV_REQUEST 6
`define SRV_OP_SUM 7

// ****************************************
// reset values
// ****************************************
`define WIDE_ZERO 16'h0000
`define NARROW_ZERO 8'h00

`endif

// [status_pkg.sv]
// status reporting types
`default_nettype none
`include "status_defines.svh"

package status_pkg;

  typedef enum logic [3:0] {
    SEL_OP_COND = `SEL_OP_COND,
    SEL_OP_EVT = `SEL_OP_EVT,
    SEL_OP_ENA = `SEL_OP_ENA,
    SEL_Q_COND = `SEL_Q_COND,
    SEL_Q_EVT = `SEL_Q_EVT,
    SEL_Q_ENA = `SEL_Q_ENA,
    SEL_STD_COND = `SEL_STD_COND,
    SEL_STD_EVT = `SEL_STD_EVT,
    SEL_STD_ENA = `SEL_STD_ENA,
    SEL_SRV_BYTE = `SEL_SRV_BYTE,
    SEL_SRV_ENA = `SEL_SRV_ENA
  } reg_sel_t;

  typedef struct packed {
    logic trig_enabled;
    logic trig_ext_src;
    logic transient_armed;
    logic const_volt;
    logic const_curr;
    logic transient_done;
    logic sample_done;
    logic list_done;
    logic list_running;
  } op_in_t;

  typedef struct packed {
    logic current_mode;
    logic voltage_mode;
    logic thermal_fault;
    logic slave_fault;
    logic volt_prot;
    logic curr_prot;
    logic ext_ref;
    logic sinking;
  } q_in_t;

endpackage

`default_nettype wire

// [status_props.sv]
// status reporting checker: port relations of the status block
`timescale 1ns/1ns
`default_nettype none
// ****
// checker
// ****
module status_props #(
  parameter int WIDE_W = 16,
  parameter int NARROW_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // watched ports
  input wire status_pkg::op_in_t op_in_i,
  input wire status_pkg::q_in_t q_in_i,
  input wire logic queue_not_empty_i,
  input wire logic out_data_avail_i,
  input wire status_pkg::reg_sel_t reg_sel_i,
  input wire logic rd_i,
  input wire logic [WIDE_W-1:0] rdata_o,
  input wire logic [NARROW_W-1:0] serial_poll_o,
  input wire logic srq_o
);
  wire rd_op = rd_i && (reg_sel_i == status_pkg::SEL_OP_COND);
  wire rd_q = rd_i && (reg_sel_i == status_pkg::SEL_Q_COND);
  wire rd_qe = rd_i && (reg_sel_i == status_pkg::SEL_Q_EVT);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_srq;
    srq_o == serial_poll_o[6]
      && (!srq_o || (serial_poll_o & 8'hb8) != 8'h00);
  endproperty
  a_srq: assert property (p_srq) else $error("srq");
  property p_avail; serial_poll_o[4] == out_data_avail_i; endproperty
  a_avail: assert property (p_avail) else $error("avail");
  property p_queue; queue_not_empty_i |-> serial_poll_o[3]; endproperty
  a_queue: assert property (p_queue) else $error("queue");
  property p_op_zero; rd_op |=> (rdata_o & 16'ha09f) == 16'h0000; endproperty
  a_op_zero: assert property (p_op_zero) else $error("opz");
  property p_op_evt; rd_op |=> (rdata_o & 16'h1200) == 16'h0000; endproperty
  a_op_evt: assert property (p_op_evt) else $error("opevt");
  property p_q_zero; rd_q |=> (rdata_o & 16'h8fb4) == 16'h0000; endproperty
  a_q_zero: assert property (p_q_zero) else $error("qz");
  property p_op_mode;
    rd_op |=> rdata_o[8] == $past(op_in_i.const_volt)
      && rdata_o[10] == $past(op_in_i.const_curr);
  endproperty
  a_op_mode: assert property (p_op_mode) else $error("mode");
  property p_clear;
    rd_qe && $stable(q_in_i) ##1 $stable(q_in_i)
      ##1 rd_qe && $stable(q_in_i) |=> rdata_o == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear");
  c_srq: cover property ($rose(srq_o));
  c_clear: cover property (rd_qe);
  c_queue: cover property (queue_not_empty_i && srq_o);
endmodule
bind status_reporting_summary status_props #(.WIDE_W(WIDE_W),
  .NARROW_W(NARROW_W)) chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .op_in_i(op_in_i), .q_in_i(q_in_i), .queue_not_empty_i(queue_not_empty_i),
  .out_data_avail_i(out_data_avail_i), .reg_sel_i(reg_sel_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .serial_poll_o(serial_poll_o), .srq_o(srq_o));
`default_nettype wire

// [host_model.sv]
// host controller model: serial poll on each service request
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // clock and status
  input wire logic ref_clk_i,
  input wire logic srq_i,
  input wire logic [7:0] poll_i,
  // poll result
  output logic [7:0] polled_o
);
  logic srq_q = 1'b0;
  initial polled_o = 8'h00;
  always @(posedge ref_clk_i) begin
    srq_q <= srq_i;
    if (srq_i && !srq_q) begin
      polled_o <= poll_i;
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
// testbench for the status reporting block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  status_pkg::op_in_t op = '0;
  status_pkg::q_in_t q = '0;
  status_pkg::reg_sel_t sel = status_pkg::SEL_OP_COND;
  logic [7:0] std = 8'h00;
  logic pin = 1'b1;
  logic qne = 1'b0;
  logic avail = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [7:0] sp;
  logic [7:0] polled;
  logic rdv;
  logic srq;
  int fails = 0;
  int n_compared = 0;
  logic [15:0] oe = 16'h0000;
  logic [15:0] qe = 16'h0000;
  logic [15:0] o_prev;
  logic [15:0] q_prev;
  always #10 ref_clk = ~ref_clk;
  status_reporting_summary uut (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .op_in_i(op), .q_in_i(q), .std_cond_i(std), .trig_pin_i(pin),
    .queue_not_empty_i(qne), .out_data_avail_i(avail), .reg_sel_i(sel),
    .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata),
    .rd_valid_o(rdv), .serial_poll_o(sp), .srq_o(srq));
  host_model host (.ref_clk_i(ref_clk), .srq_i(srq), .poll_i(sp),
    .polled_o(polled));
  // ****
  // helpers
  // ****
  task automatic finish_test;
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, act);
    n_compared++;
    if (act !== exp) begin
      fails++;
      $display("wrong value %s exp %h got %h", name, exp, act);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic rreg(input status_pkg::reg_sel_t s, input logic [15:0] e);
    sel = s;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    chk("rd_valid", 16'h0001, rdv);
    chk(s.name(), e, rdata);
    cyc(1);
  endtask
  task automatic wreg(input status_pkg::reg_sel_t s, input logic [15:0] d);
    sel = s;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask
  function automatic logic [15:0] op_exp(status_pkg::op_in_t o);
    op_exp = {1'b0, o.list_running, 2'b0, o.sample_done, o.const_curr,
      1'b0, o.const_volt, 1'b0, o.transient_armed, o.trig_enabled, 5'b0};
  endfunction
  function automatic logic [15:0] q_exp(status_pkg::q_in_t v);
    q_exp = {1'b0, v.sinking, v.curr_prot | (v.ext_ref & v.volt_prot),
      v.volt_prot | (v.ext_ref & v.curr_prot), 5'b0, v.slave_fault, 2'b0,
      v.thermal_fault, 1'b0, v.voltage_mode, v.current_mode};
  endfunction
  // ****
  // tests
  // ****
  initial begin
    void'($urandom(32'h9727));
    cyc(8);
    rst_b = 1'b1;
    cyc(2);
    rreg(status_pkg::SEL_Q_EVT, 16'h0000);
    rreg(status_pkg::SEL_SRV_ENA, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      o_prev = op_exp(op);
      q_prev = q_exp(q);
      op = 9'($urandom) & 9'h17f;
      q = 8'($urandom);
      oe = oe | (op_exp(op) & ~o_prev)
        | {3'b0, op.list_done, 2'b0, op.transient_done, 9'b0};
      qe = qe | (q_exp(q) & ~q_prev);
      cyc(1);
      rreg(status_pkg::SEL_OP_COND, op_exp(op));
      rreg(status_pkg::SEL_Q_COND, q_exp(q));
    end
    op = '0;
    q = '0;
    cyc(2);
    rreg(status_pkg::SEL_OP_EVT, oe);
    rreg(status_pkg::SEL_Q_EVT, qe);
    wreg(status_pkg::SEL_Q_ENA, 16'h0008);
    wreg(status_pkg::SEL_SRV_ENA, 16'h0008);
    rreg(status_pkg::SEL_Q_EVT, 16'h0000);
    chk("poll_idle", 16'h0000, sp);
    q.thermal_fault = 1'b1;
    cyc(2);
    chk("poll_q", 16'h0048, sp);
    chk("srq", 16'h0001, srq);
    chk("host", 16'h0048, polled);
    rreg(status_pkg::SEL_Q_EVT, 16'h0008);
    chk("poll_ok", 16'h0000, sp);
    rreg(status_pkg::SEL_Q_EVT, 16'h0000);
    op = '{transient_done: 1'b1, list_done: 1'b1, default: 1'b0};
    cyc(1);
    op = '0;
    rreg(status_pkg::SEL_OP_EVT, 16'h1200);
    qne = 1'b1;
    avail = 1'b1;
    cyc(1);
    chk("poll_queue", 16'h0058, sp);
    qne = 1'b0;
    avail = 1'b0;
    wreg(status_pkg::SEL_STD_ENA, 16'h0001);
    wreg(status_pkg::SEL_OP_ENA, 16'h0100);
    wreg(status_pkg::SEL_SRV_ENA, 16'h00a0);
    std = 8'h01;
    op.const_volt = 1'b1;
    cyc(2);
    chk("poll_sum", 16'h00e0, sp);
    wreg(status_pkg::SEL_OP_COND, 16'hffff);
    rreg(status_pkg::SEL_OP_ENA, 16'h0100);
    rreg(status_pkg::SEL_STD_ENA, 16'h0001);
    rreg(status_pkg::SEL_Q_ENA, 16'h0008);
    rreg(status_pkg::SEL_SRV_BYTE, 16'h00e0);
    rreg(status_pkg::SEL_STD_COND, 16'h0001);
    rreg(status_pkg::reg_sel_t'(4'hf), 16'h0000);
    wreg(status_pkg::SEL_SRV_ENA, 16'h0040);
    chk("poll_b6", 16'h00a0, sp);
    op = '{trig_ext_src: 1'b1, default: 1'b0};
    std = 8'h00;
    pin = 1'b0;
    cyc(5);
    rreg(status_pkg::SEL_OP_COND, 16'h0020);
    pin = 1'b1;
    cyc(5);
    rreg(status_pkg::SEL_OP_COND, 16'h0000);
    rst_b = 1'b0;
    cyc(1);
    rst_b = 1'b1;
    cyc(1);
    chk("srq_rst", 16'h0000, srq);
    rreg(status_pkg::SEL_STD_EVT, 16'h0000);
    rreg(status_pkg::SEL_OP_ENA, 16'h0000);
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
